// ---- rtl/lsl_pkg.sv ----
// Purpose: Shared constants and types for the indicator output and strap latch block
// Assumes: 50 MHz core clock, 5-bit register address, 16-bit register data
// Notes:   Register offsets are byte-free indices on the plain register port
package lsl_pkg;

  // Register offsets
  localparam logic [4:0] ADDR_CTRL  = 5'h00;  // Basic control register
  localparam logic [4:0] ADDR_VCTRL = 5'h1e;  // Vendor control register
  localparam logic [4:0] ADDR_STAT  = 5'h1f;  // Block status register

  // Field positions
  localparam int ANEG_BIT   = 12;  // Auto-negotiation enable in control
  localparam int SPEED_BIT  = 13;  // Speed select in control
  localparam int MODE_LO    = 14;  // Indicator mode field, low bit
  localparam int MODE_HI    = 15;  // Indicator mode field, high bit
  localparam int ST_FIBER   = 0;   // Status: fiber mode latched
  localparam int ST_NOFEF   = 1;   // Status: far-end fault disabled
  localparam int ST_LINK    = 2;   // Status: link up
  localparam int ST_ACT     = 3;   // Status: activity
  localparam int ST_SPEED   = 4;   // Status: 100 Mbps
  localparam int ST_BLINK   = 5;   // Status: blink phase

  // Reset values
  localparam logic [1:0] MODE_RST   = 2'h0;  // Indicator mode after reset
  localparam logic       FIBER_SPD  = 1'h1;  // Speed bit loaded by a fiber-mode reset

  // Timing
  localparam int unsigned CLK_HZ     = 50_000_000;  // Core clock rate
  localparam int unsigned BLINK_MS   = 100;         // Blink half period in ms
  localparam int unsigned BLINK_CYC  = (CLK_HZ / 1000) * BLINK_MS;

  // Indicator modes
  typedef enum logic [1:0] {
    MODE_LINKACT_SPEED = 2'b00,
    MODE_LINK_ACT      = 2'b01,
    MODE_RSV2          = 2'b10,
    MODE_RSV3          = 2'b11
  } lsl_mode_t;

  // Line state from the transceiver core
  typedef struct packed {
    logic linkUp;    // Link established
    logic activity;  // Traffic seen
    logic speed100;  // 1 for 100 Mbps, 0 for 10 Mbps
  } lsl_line_t;

  // Register port request
  typedef struct packed {
    logic [4:0]  addr;   // Register offset
    logic [15:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } lsl_req_t;

endpackage

// ---- rtl/lsl_led_strap.sv ----
// Purpose: Drives two indicator pins and latches their strap levels at reset
// Assumes: Line state comes from logic on clk; pins and fiber_enable are asynchronous
// Notes:   Pins are released (oe high) throughout reset so pull resistors set straps
//
// Function
// - Mode field 15:14 at 1Eh selects behaviour
// - First pin: link/activity or link only
// - Second pin: speed, or activity blink
// - Copper: first strap loads auto-negotiation bit 12
// - Fiber mode: auto-negotiation forced off
// - Copper-only part: second strap loads speed bit 13
// - Fiber part, copper mode: same speed latch
// - Fiber mode: second strap disables far-end fault
// - Pins are inputs during reset, outputs otherwise
// - Fiber enable low copper, high fiber
// - Reset is active low; straps sampled then
`timescale 1ns/1ps
module lsl_led_strap
  import lsl_pkg::*;
#(
  parameter bit          FIBER_CAPABLE = 1'b1,       // Part has fiber mode
  parameter int unsigned BLINK_CYCLES  = BLINK_CYC   // Cycles per blink half period
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire lsl_req_t    req,
  output      logic [15:0] rdata,
  // Line state
  input  wire lsl_line_t   line,
  // Fiber mode select pin
  input  wire logic        fiber_enable,
  // First indicator pin
  input  wire logic        linkIndicatorIn,
  output      logic        link_indicator_out,
  output      logic        linkIndicatorOeN,
  // Second indicator pin
  input  wire logic        speedIndicatorIn,
  output      logic        speed_indicator_out,
  output      logic        speedIndicatorOeN,
  // Strap results
  output      logic        autoneg_enable_strap,
  output      logic        speedSelect,
  output      logic        far_end_fault,
  output      logic        fiberMode
);

  // Refuse a blink period the counter cannot express
  if (BLINK_CYCLES < 2) begin : g_chk
    $error("BLINK_CYCLES must be at least 2");
  end

  // Synchronisers: stage one feeds stage two only
  logic [2:0] syncA;  // First stage: link pin, speed pin, fiber enable
  logic [2:0] syncB;  // Second stage, safe to read

  // Left without reset so that the straps travel through during reset
  always_ff @(posedge clk) begin
    syncA <= {linkIndicatorIn, speedIndicatorIn, fiber_enable};
    syncB <= syncA;
  end

  logic linkPin;   // Synchronised first pin
  logic speedPin;  // Synchronised second pin
  logic fiberPin;  // Synchronised fiber enable
  assign linkPin  = syncB[2];
  assign speedPin = syncB[1];
  assign fiberPin = syncB[0];

  // Strap and register state
  lsl_mode_t   ledMode, next_ledMode;          // Indicator mode
  logic        aneg, next_aneg;                // Auto-negotiation enable
  logic        speed, next_speed;              // Speed select
  logic        noFef, next_noFef;              // Far-end fault disabled
  logic        fiber, next_fiber;              // Fiber mode latched
  logic [15:0] rd, next_rd;                    // Read data register
  logic        blink, next_blink;              // Blink phase, also shown in status

  // Register and strap next values
  always_comb begin
    next_ledMode = ledMode;
    next_aneg    = aneg;
    next_speed   = speed;
    next_noFef   = noFef;
    next_fiber   = fiber;
    next_rd      = 16'h0000;
    if (!resetn) begin
      // Straps follow the pins for as long as reset is held
      next_ledMode = lsl_mode_t'(MODE_RST);
      next_fiber   = FIBER_CAPABLE && fiberPin;
      if (FIBER_CAPABLE && fiberPin) begin
        next_aneg  = 1'b0;
        next_speed = FIBER_SPD;
        next_noFef = speedPin;
      end else begin
        next_aneg  = linkPin;
        next_speed = speedPin;
        next_noFef = 1'b0;
      end
    end else begin
      // Writes; in fiber mode auto-negotiation stays off
      if (req.wr) begin
        if (req.addr == ADDR_CTRL) begin
          next_aneg  = req.wdata[ANEG_BIT] && !fiber;
          next_speed = req.wdata[SPEED_BIT];
        end else if (req.addr == ADDR_VCTRL) begin
          next_ledMode = lsl_mode_t'(req.wdata[MODE_HI:MODE_LO]);
        end
      end
      // Reads answer in the next cycle only; unmapped offsets read zero
      if (req.rd) begin
        if (req.addr == ADDR_CTRL) begin
          next_rd[ANEG_BIT]  = aneg;
          next_rd[SPEED_BIT] = speed;
        end else if (req.addr == ADDR_VCTRL) begin
          next_rd[MODE_HI:MODE_LO] = ledMode;
        end else if (req.addr == ADDR_STAT) begin
          next_rd[ST_FIBER] = fiber;
          next_rd[ST_NOFEF] = noFef;
          next_rd[ST_LINK]  = line.linkUp;
          next_rd[ST_ACT]   = line.activity;
          next_rd[ST_SPEED] = line.speed100;
          next_rd[ST_BLINK] = blink;
        end
      end
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    ledMode <= next_ledMode;
    aneg    <= next_aneg;
    speed   <= next_speed;
    noFef   <= next_noFef;
    fiber   <= next_fiber;
    rd      <= next_rd;
  end

  // Blink divider: a tick pulse every half period flips the phase
  logic [31:0] blinkCnt, next_blinkCnt;  // Half-period counter
  logic        blinkTick;                // One-cycle enable

  assign blinkTick = (blinkCnt == 32'(BLINK_CYCLES - 1));

  // Blink next values
  always_comb begin
    next_blinkCnt = blinkTick ? 32'h0000_0000 : blinkCnt + 32'h0000_0001;
    next_blink    = blinkTick ? !blink : blink;
    if (!resetn) begin
      next_blinkCnt = 32'h0000_0000;
      next_blink    = 1'b0;
    end
  end

  // Register the blink state
  always_ff @(posedge clk) begin
    blinkCnt <= next_blinkCnt;
    blink    <= next_blink;
  end

  // Indicator drive; high is off since the LED hangs from the supply
  logic ledA, next_ledA;  // First pin level
  logic ledB, next_ledB;  // Second pin level
  logic oeN, next_oeN;    // Shared output enable, low drives

  // Indicator next values
  always_comb begin
    next_oeN  = !resetn;  // Released during reset for strap pulls
    next_ledA = 1'b1;
    next_ledB = 1'b1;
    case (ledMode)
      MODE_LINKACT_SPEED: begin
        next_ledA = !line.linkUp ? 1'b1 : (line.activity ? blink : 1'b0);
        next_ledB = !line.speed100;
      end
      MODE_LINK_ACT: begin
        next_ledA = !line.linkUp;
        next_ledB = line.activity ? blink : 1'b1;
      end
      default: begin
        // Reserved modes leave both LEDs dark
        next_ledA = 1'b1;
        next_ledB = 1'b1;
      end
    endcase
    if (!resetn) begin
      next_ledA = 1'b1;
      next_ledB = 1'b1;
    end
  end

  // Register the indicator drive
  always_ff @(posedge clk) begin
    ledA <= next_ledA;
    ledB <= next_ledB;
    oeN  <= next_oeN;
  end

  // Outputs
  assign rdata                = rd;
  assign link_indicator_out   = ledA;
  assign speed_indicator_out  = ledB;
  assign linkIndicatorOeN     = oeN;
  assign speedIndicatorOeN    = oeN;
  assign autoneg_enable_strap = aneg;
  assign speedSelect          = speed;
  assign far_end_fault        = noFef;
  assign fiberMode            = fiber;

  // Checks
  sequence s_release;
    $rose(resetn);
  endsequence

  sequence s_released_pins;
    oeN ##1 !oeN;
  endsequence

  AST_MODE_FIELD: assert property (@(posedge clk) disable iff (!resetn)
    req.wr && req.addr == ADDR_VCTRL |=> ledMode == $past(req.wdata[MODE_HI:MODE_LO]))
    else $error("mode field not loaded");
  AST_LINKPIN_NOLINK: assert property (@(posedge clk) disable iff (!resetn)
    resetn && !line.linkUp && ledMode[1] == 1'b0 |=> ledA)
    else $error("first pin not off without link");
  AST_LINKPIN_LINK: assert property (@(posedge clk) disable iff (!resetn)
    resetn && line.linkUp && ledMode == MODE_LINK_ACT |=> !ledA)
    else $error("first pin not on with link");
  AST_SPEEDPIN_SPEED: assert property (@(posedge clk) disable iff (!resetn)
    resetn && ledMode == MODE_LINKACT_SPEED |=> ledB == !$past(line.speed100))
    else $error("second pin does not show speed");
  AST_ANEG_STRAP: assert property (@(posedge clk) disable iff (!resetn)
    s_release |-> aneg == (fiber ? 1'b0 : $past(linkPin)))
    else $error("auto-negotiation strap wrong");
  AST_SPEED_STRAP: assert property (@(posedge clk) disable iff (!resetn)
    s_release ##0 !fiber |-> speed == $past(speedPin) && !noFef)
    else $error("speed strap wrong");
  AST_NOFEF_STRAP: assert property (@(posedge clk) disable iff (!resetn)
    s_release ##0 fiber |-> noFef == $past(speedPin) && !aneg)
    else $error("far-end fault strap wrong");
  AST_PIN_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
    s_release |-> s_released_pins)
    else $error("pins not handed over at reset release");
  AST_BLINK_TICK: assert property (@(posedge clk) disable iff (!resetn)
    blinkTick |=> blink != $past(blink) && blinkCnt == 32'h0000_0000)
    else $error("blink phase did not flip");

endmodule

// ---- sim/lsl_strap_pull.sv ----
// Purpose: Board side of the two indicator pins: LEDs plus strap pull resistors
// Assumes: Straps are set by the bench before reset
// Notes:   A released pin shows its pull level, never the last driven value
`timescale 1ns/1ps
module lsl_strap_pull (
  // Device drive
  input  wire logic linkOut,
  input  wire logic linkOeN,
  input  wire logic speedOut,
  input  wire logic speedOeN,
  // Strap resistor levels
  input  wire logic linkStrap,
  input  wire logic speedStrap,
  // Pin levels
  output      logic linkPin,
  output      logic speedPin
);
  // Released pin goes to the resistor level, driven pin to the device level
  assign linkPin  = linkOeN ? linkStrap : linkOut;
  assign speedPin = speedOeN ? speedStrap : speedOut;
endmodule

// ---- sim/lsl_led_strap_test.sv ----
// Purpose: Self-checking bench for the indicator and strap latch block
// Assumes: Blink half period shortened to 4 cycles
// Notes:   Straps and fiber pin set before each reset
`timescale 1ns/1ps
module lsl_led_strap_test;
  import lsl_pkg::*;
  localparam int BLK = 4;  // Short blink keeps the run brief
  logic        clk, resetn, fiberEn, lStrap, sStrap, lPin, sPin;
  logic        lOut, lOeN, sOut, sOeN, aneg, spd, fef, fib;
  logic [15:0] rdata;
  lsl_req_t    req;
  lsl_line_t   line;
  int          failures, n_compared, cyc;

  lsl_led_strap #(.FIBER_CAPABLE(1'b1), .BLINK_CYCLES(BLK)) u_lsl_led_strap (
    .clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .line(line),
    .fiber_enable(fiberEn), .linkIndicatorIn(lPin), .link_indicator_out(lOut),
    .linkIndicatorOeN(lOeN), .speedIndicatorIn(sPin), .speed_indicator_out(sOut),
    .speedIndicatorOeN(sOeN), .autoneg_enable_strap(aneg), .speedSelect(spd),
    .far_end_fault(fef), .fiberMode(fib));
  lsl_strap_pull u_lsl_strap_pull (
    .linkOut(lOut), .linkOeN(lOeN), .speedOut(sOut), .speedOeN(sOeN),
    .linkStrap(lStrap), .speedStrap(sStrap), .linkPin(lPin), .speedPin(sPin));

  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard: a few thousand cycles is far above the planned run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Reset held 20 cycles with the given straps and fiber pin
  task automatic do_reset(input logic f, input logic ls, input logic ss);
    @(posedge clk);
    resetn  <= 1'b0;
    fiberEn <= f;
    lStrap  <= ls;
    sStrap  <= ss;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic test_straps(input logic f, input logic ls, input logic ss);
    do_reset(f, ls, ss);
    chk({lOeN, sOeN}, 16'h0000);
    chk(fib, f);
    chk(aneg, f ? 1'b0 : ls);
    if (!f) chk(spd, ss);
    else chk(fef, ss);
    if (f) chk(spd, FIBER_SPD);
    $display("straps fiber=%0d done", f);
  endtask

  // Apply line state, then check both pins two cycles later
  task automatic leds(input lsl_line_t l, input logic ea, input logic eb);
    @(posedge clk);
    line <= l;
    repeat (2) @(posedge clk);
    #1 chk({lOut, sOut}, {ea, eb});
  endtask

  // Count pin flips over four half periods
  task automatic blink(input logic pickLink, input int exp);
    logic p;
    int   n;
    n = 0;
    repeat (2) @(posedge clk);
    #1 p = pickLink ? lOut : sOut;
    repeat (4 * BLK) begin
      @(posedge clk);
      #1 if ((pickLink ? lOut : sOut) !== p) n++;
      p = pickLink ? lOut : sOut;
    end
    chk(16'(n), 16'(exp));
  endtask

  task automatic test_modes();
    logic [15:0] d;
    wr(ADDR_VCTRL, 16'h4000);
    rd(ADDR_VCTRL, d);
    chk(d[15:14], 2'h1);
    leds('{linkUp: 1'b0, activity: 1'b0, speed100: 1'b1}, 1'b1, 1'b1);
    leds('{linkUp: 1'b1, activity: 1'b0, speed100: 1'b1}, 1'b0, 1'b1);
    @(posedge clk);
    line <= '{linkUp: 1'b1, activity: 1'b1, speed100: 1'b1};
    blink(1'b0, 4);
    wr(ADDR_VCTRL, 16'h0000);
    leds('{linkUp: 1'b1, activity: 1'b0, speed100: 1'b1}, 1'b0, 1'b0);
    leds('{linkUp: 1'b0, activity: 1'b0, speed100: 1'b0}, 1'b1, 1'b1);
    @(posedge clk);
    line <= '{linkUp: 1'b1, activity: 1'b1, speed100: 1'b0};
    blink(1'b1, 4);
    for (int m = 2; m < 4; m++) begin
      wr(ADDR_VCTRL, {m[1:0], 14'h0000});
      leds('{linkUp: 1'b1, activity: 1'b0, speed100: 1'b1}, 1'b1, 1'b1);
    end
    rd(5'h05, d);
    chk(d, 16'h0000);
    $display("modes done");
  endtask

  // Register port: fiber keeps auto-negotiation off, copper takes the write
  task automatic test_regs();
    logic [15:0] d;
    wr(ADDR_CTRL, 16'h3000);
    rd(ADDR_CTRL, d);
    chk(d, 16'h2000);
    @(posedge clk);
    #1 chk(rdata, 16'h0000);
    // Blink phase bit is masked since its phase is not tracked here
    rd(ADDR_STAT, d);
    chk(d & 16'hffdf, 16'h0015);
    do_reset(1'b0, 1'b0, 1'b1);
    wr(ADDR_CTRL, 16'h1000);
    rd(ADDR_CTRL, d);
    chk(d, 16'h1000);
    chk({aneg, spd, fib}, 16'h0004);
    $display("regs done");
  endtask

  task automatic test_done();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    resetn     = 1'b0;
    fiberEn    = 1'b0;
    lStrap     = 1'b1;
    sStrap     = 1'b1;
    req        = '0;
    line       = '0;
    failures   = 0;
    n_compared = 0;
    cyc        = 0;
    test_straps(1'b0, 1'b0, 1'b1);
    test_straps(1'b0, 1'b1, 1'b0);
    test_straps(1'b1, 1'b1, 1'b1);
    test_straps(1'b1, 1'b1, 1'b0);
    test_modes();
    test_regs();
    test_done();
  end
endmodule
